// ===== ctm_maint.sv
// Cache and TLB maintenance and lockdown logic of the system control coprocessor
// Operation
// RULE1 - Cache operation chosen from operand register and secondary opcode of the write
// RULE2 - c0 opcode 4 halts in low power until an interrupt
// RULE3 - c5: opcode 0 invalidates whole instruction cache, 1 one line
// RULE4 - c6: opcode 0 invalidates whole data cache, 1 one line
// RULE5 - c7 opcode 0 invalidates both caches together
// RULE6 - Invalidated line is marked invalid and misses until reallocated
// RULE7 - Clean writes unwritten dirty data cache content to memory at once
// RULE8 - c10 cleans one data cache entry, opcode 1 by address, 2 by index
// RULE9 - c10 opcode 4 stalls until write buffer is empty
// RULE10 - c13 opcode 1 prefetches the addressed line into instruction cache
// RULE11 - c14 cleans then invalidates one data entry by address or index
// RULE12 - Address form uses data bits 31 to 5, low bits zero
// RULE13 - Index form uses line bits 31 to 26 and segment bits 7 to 5
// RULE14 - Software must not read op registers nor write unlisted codes
// RULE15 - TLB op: 5 instruction, 6 data; opcode 0 all, 1 one entry
// RULE16 - TLB operand register 7 invalidates both TLBs together
// RULE17 - Single TLB entry chosen by data bits 31 to 10
// RULE18 - Cache lockdown register resets to zero
// RULE19 - Lines below lockdown base are kept; victim pointer picks next linefill
// RULE20 - Cache lockdown read returns base in bits 31 to 26 only
// RULE21 - Lockdown write sets base and victim; opcode 0 data, 1 instruction
// RULE22 - Separate data and instruction TLB lockdown registers, both reset zero
// RULE23 - TLB victim stays between lockdown base and 63
// RULE24 - Entry written with preserve bit set survives invalidate-all
`timescale 1ns/100ps
`include "ctm_map.svh"
module ctm_maint
	import ctm_pkg::*;
(
	input wire logic ref_clk, // Core clock, 100 MHz
	input wire logic resetn, // Synchronous reset, active low
	input wire logic cp_wr, // Coprocessor write strobe
	input wire logic cp_rd, // Coprocessor read strobe
	input wire ctm_xfer_t cp_xfer, // Register number, fields, data
	output logic [31:0] cp_rdata, // Read data
	output logic core_stall, // Hold the core
	output logic low_power, // Waiting for interrupt
	input wire logic irq_pending, // Interrupt request from core domain
	input wire logic wbuf_empty, // Write buffer fully stored
	output ctm_cache_cmd_t cache_cmd, // Cache operation, one cycle
	input wire logic cache_done, // Cache array finished operation
	output ctm_tlb_cmd_t tlb_cmd, // TLB operation, one cycle
	output logic [5:0] dc_victim, // Data cache linefill victim line
	output logic [5:0] ic_victim, // Instruction cache linefill victim line
	output logic [5:0] dc_lock_base, // Data cache lockdown base
	output logic [5:0] ic_lock_base, // Instruction cache lockdown base
	input wire logic dc_linefill, // Data cache linefill happened
	input wire logic ic_linefill, // Instruction cache linefill happened
	output logic [5:0] dtlb_victim, // Data TLB victim entry
	output logic [5:0] itlb_victim, // Instruction TLB victim entry
	output logic [5:0] dtlb_base, // Data TLB lockdown base
	output logic [5:0] itlb_base, // Instruction TLB lockdown base
	output logic dtlb_preserve, // Preserve bit for next data TLB fill
	output logic itlb_preserve, // Preserve bit for next instruction TLB fill
	input wire logic dtlb_refill, // Data TLB entry replaced
	input wire logic itlb_refill, // Instruction TLB entry replaced
	output logic cache_busy // A cache operation is outstanding
);
	logic [3:0] coproc_operand_reg;
	logic [2:0] op2;
	logic [31:0] wdata;
	logic cache_wr;
	logic tlb_wr;
	logic clock_wr;
	logic tlock_wr;
	ctm_cache_op_t cop_next;
	ctm_tlb_op_t top_next;
	ctm_stall_t stall_reg;
	ctm_stall_t stall_next;
	logic [5:0] dc_base_reg;
	logic [5:0] ic_base_reg;
	logic [5:0] dc_vic_reg;
	logic [5:0] ic_vic_reg;
	logic [31:0] dtlb_lock_reg;
	logic [31:0] itlb_lock_reg;
	logic busy_reg;
	// Field split of the transfer
	assign coproc_operand_reg = cp_xfer.operand_reg;
	assign op2 = cp_xfer.secondary_opcode;
	assign wdata = cp_xfer.data;
	assign cache_wr = cp_wr && cp_xfer.reg_num == `CTM_REG_CACHE_OP;
	assign tlb_wr = cp_wr && cp_xfer.reg_num == `CTM_REG_TLB_OP;
	assign clock_wr = cp_wr && cp_xfer.reg_num == `CTM_REG_CACHE_LOCK && coproc_operand_reg == `CTM_CRM_C0;
	assign tlock_wr = cp_wr && cp_xfer.reg_num == `CTM_REG_TLB_LOCK && coproc_operand_reg == `CTM_CRM_C0;

	// Cache operation decode; unlisted codes do nothing
	always_comb
	begin
		cop_next = CTM_CNONE; // RULE1
		if (cache_wr)
		begin
			unique case ({coproc_operand_reg, op2})
				{`CTM_CRM_C5, `CTM_OP2_0}: cop_next = CTM_INV_I_ALL; // RULE3
				{`CTM_CRM_C5, `CTM_OP2_1}: cop_next = CTM_INV_I_LINE; // RULE3
				{`CTM_CRM_C6, `CTM_OP2_0}: cop_next = CTM_INV_D_ALL; // RULE4
				{`CTM_CRM_C6, `CTM_OP2_1}: cop_next = CTM_INV_D_LINE; // RULE4
				{`CTM_CRM_C7, `CTM_OP2_0}: cop_next = CTM_INV_ID_ALL; // RULE5
				{`CTM_CRM_C10, `CTM_OP2_1}: cop_next = CTM_CLEAN_D_MVA; // RULE8
				{`CTM_CRM_C10, `CTM_OP2_2}: cop_next = CTM_CLEAN_D_IDX; // RULE8
				{`CTM_CRM_C13, `CTM_OP2_1}: cop_next = CTM_PREFETCH_I; // RULE10
				{`CTM_CRM_C14, `CTM_OP2_1}: cop_next = CTM_CLINV_D_MVA; // RULE11
				{`CTM_CRM_C14, `CTM_OP2_2}: cop_next = CTM_CLINV_D_IDX; // RULE11
				default: cop_next = CTM_CNONE; // RULE14
			endcase
		end
	end

	// TLB operation decode; operand 7 ignores the opcode
	always_comb
	begin
		top_next = CTM_TNONE;
		if (tlb_wr)
		begin
			if (coproc_operand_reg == `CTM_CRM_C7)
				top_next = CTM_TINV_ID_ALL; // RULE16
			else if (coproc_operand_reg == `CTM_CRM_C5 && op2 == `CTM_OP2_0)
				top_next = CTM_TINV_I_ALL; // RULE15
			else if (coproc_operand_reg == `CTM_CRM_C5 && op2 == `CTM_OP2_1)
				top_next = CTM_TINV_I_ENTRY; // RULE15
			else if (coproc_operand_reg == `CTM_CRM_C6 && op2 == `CTM_OP2_0)
				top_next = CTM_TINV_D_ALL; // RULE15
			else if (coproc_operand_reg == `CTM_CRM_C6 && op2 == `CTM_OP2_1)
				top_next = CTM_TINV_D_ENTRY; // RULE15
		end
	end

	// Cache command register, one-cycle operation with its address fields
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			cache_cmd <= '0;
		else
		begin
			cache_cmd.op <= cop_next; // RULE6 RULE7
			cache_cmd.mva <= wdata[`CTM_MVA_HI:`CTM_MVA_LO]; // RULE12
			cache_cmd.line_index <= wdata[`CTM_IDX_HI:`CTM_IDX_LO]; // RULE13
			cache_cmd.segment <= wdata[`CTM_SET_HI:`CTM_SET_LO]; // RULE13
		end
	end

	// TLB command register; preserved entries are spared by the TLB itself
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			tlb_cmd <= '0;
		else
		begin
			tlb_cmd.op <= top_next; // RULE15 RULE24
			tlb_cmd.mva <= wdata[`CTM_MVA_HI:`CTM_TLB_MVA_LO]; // RULE17
		end
	end

	// Busy until the cache array acknowledges; a new start wins over done
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			busy_reg <= 1'b0;
		else if (cop_next != CTM_CNONE)
			busy_reg <= 1'b1;
		else if (cache_done)
			busy_reg <= 1'b0;
	end
	assign cache_busy = busy_reg;

	// Stall sequencer for wait-for-interrupt and write buffer drain
	always_comb
	begin
		stall_next = stall_reg;
		unique case (stall_reg)
			CTM_RUN:
			begin
				if (cache_wr && coproc_operand_reg == `CTM_CRM_C0 && op2 == `CTM_OP2_4)
					stall_next = CTM_WFI; // RULE2
				else if (cache_wr && coproc_operand_reg == `CTM_CRM_C10 && op2 == `CTM_OP2_4)
					stall_next = CTM_DRAIN; // RULE9
			end
			CTM_WFI:
				if (irq_pending)
					stall_next = CTM_RUN; // RULE2
			CTM_DRAIN:
				if (wbuf_empty)
					stall_next = CTM_RUN; // RULE9
			default: stall_next = CTM_RUN;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			stall_reg <= CTM_RUN;
		else
			stall_reg <= stall_next;
	end
	// Stall is registered so the core sees it from the cycle after the write
	assign core_stall = stall_reg != CTM_RUN;
	assign low_power = stall_reg == CTM_WFI;

	// Cache lockdown base and victim pointers, per cache
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			dc_base_reg <= `CTM_PTR_RESET; // RULE18
			ic_base_reg <= `CTM_PTR_RESET; // RULE18
			dc_vic_reg <= `CTM_PTR_RESET;
			ic_vic_reg <= `CTM_PTR_RESET;
		end
		else
		begin
			if (clock_wr && op2 == `CTM_OP2_0)
			begin
				dc_base_reg <= wdata[`CTM_IDX_HI:`CTM_IDX_LO]; // RULE21
				dc_vic_reg <= wdata[`CTM_IDX_HI:`CTM_IDX_LO]; // RULE21
			end
			else if (dc_linefill)
				dc_vic_reg <= (dc_vic_reg == `CTM_TLB_TOP) ? dc_base_reg : dc_vic_reg + 6'h01; // RULE19
			if (clock_wr && op2 == `CTM_OP2_1)
			begin
				ic_base_reg <= wdata[`CTM_IDX_HI:`CTM_IDX_LO]; // RULE21
				ic_vic_reg <= wdata[`CTM_IDX_HI:`CTM_IDX_LO]; // RULE21
			end
			else if (ic_linefill)
				ic_vic_reg <= (ic_vic_reg == `CTM_TLB_TOP) ? ic_base_reg : ic_vic_reg + 6'h01; // RULE19
		end
	end
	assign dc_victim = dc_vic_reg;
	assign ic_victim = ic_vic_reg;
	assign dc_lock_base = dc_base_reg;
	assign ic_lock_base = ic_base_reg;

	// TLB lockdown registers; victim wraps back to the base after entry 63
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			dtlb_lock_reg <= `CTM_LOCK_RESET; // RULE22
			itlb_lock_reg <= `CTM_LOCK_RESET; // RULE22
		end
		else
		begin
			if (tlock_wr && op2 == `CTM_OP2_0)
				dtlb_lock_reg <= wdata; // RULE22
			else if (dtlb_refill)
				dtlb_lock_reg[`CTM_VIC_HI:`CTM_VIC_LO] <=
					(dtlb_victim >= `CTM_TLB_TOP || dtlb_victim < dtlb_base) ?
					dtlb_base : dtlb_victim + 6'h01; // RULE23
			if (tlock_wr && op2 == `CTM_OP2_1)
				itlb_lock_reg <= wdata; // RULE22
			else if (itlb_refill)
				itlb_lock_reg[`CTM_VIC_HI:`CTM_VIC_LO] <=
					(itlb_victim >= `CTM_TLB_TOP || itlb_victim < itlb_base) ?
					itlb_base : itlb_victim + 6'h01; // RULE23
		end
	end
	assign dtlb_base = dtlb_lock_reg[`CTM_IDX_HI:`CTM_IDX_LO];
	assign itlb_base = itlb_lock_reg[`CTM_IDX_HI:`CTM_IDX_LO];
	assign dtlb_victim = dtlb_lock_reg[`CTM_VIC_HI:`CTM_VIC_LO];
	assign itlb_victim = itlb_lock_reg[`CTM_VIC_HI:`CTM_VIC_LO];
	assign dtlb_preserve = dtlb_lock_reg[`CTM_PRESERVE_BIT]; // RULE24
	assign itlb_preserve = itlb_lock_reg[`CTM_PRESERVE_BIT]; // RULE24

	// Registered read data; maintenance registers read as zero
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
			cp_rdata <= `CTM_LOCK_RESET;
		else if (cp_rd)
		begin
			cp_rdata <= `CTM_LOCK_RESET;
			if (cp_xfer.reg_num == `CTM_REG_CACHE_LOCK)
				cp_rdata[`CTM_IDX_HI:`CTM_IDX_LO] <= (op2 == `CTM_OP2_1) ? ic_base_reg :
					dc_base_reg; // RULE20
			else if (cp_xfer.reg_num == `CTM_REG_TLB_LOCK)
				cp_rdata <= (op2 == `CTM_OP2_1) ? itlb_lock_reg : dtlb_lock_reg;
		end
	end

	// Checks; each looks one cycle after the decoded write or event
	wfi_entry_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE2
		cache_wr && coproc_operand_reg == `CTM_CRM_C0 && op2 == `CTM_OP2_4 && !core_stall |=> low_power)
		else $error("wait for interrupt not entered");
	wfi_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE2
		low_power && !irq_pending |=> low_power)
		else $error("left low power without interrupt");
	drain_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE9
		stall_reg == CTM_DRAIN && !wbuf_empty |=> core_stall)
		else $error("stall released before write buffer empty");
	inv_i_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE3
		cache_wr && coproc_operand_reg == `CTM_CRM_C5 && op2 == `CTM_OP2_0 |=> cache_cmd.op == CTM_INV_I_ALL)
		else $error("instruction cache invalidate not issued");
	inv_d_line_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE4
		cache_wr && coproc_operand_reg == `CTM_CRM_C6 && op2 == `CTM_OP2_1 |=> cache_cmd.op == CTM_INV_D_LINE
		&& cache_cmd.mva == $past(wdata[`CTM_MVA_HI:`CTM_MVA_LO]))
		else $error("data cache line invalidate wrong");
	inv_both_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE5
		cache_wr && coproc_operand_reg == `CTM_CRM_C7 && op2 == `CTM_OP2_0 |=> cache_cmd.op == CTM_INV_ID_ALL)
		else $error("combined invalidate not issued");
	clean_idx_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE8
		cache_wr && coproc_operand_reg == `CTM_CRM_C10 && op2 == `CTM_OP2_2 |=> cache_cmd.op == CTM_CLEAN_D_IDX
		&& cache_cmd.line_index == $past(wdata[`CTM_IDX_HI:`CTM_IDX_LO]))
		else $error("index clean wrong");
	prefetch_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE10
		cache_wr && coproc_operand_reg == `CTM_CRM_C13 && op2 == `CTM_OP2_1 |=> cache_cmd.op == CTM_PREFETCH_I)
		else $error("instruction prefetch not issued");
	clinv_idx_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE11
		cache_wr && coproc_operand_reg == `CTM_CRM_C14 && op2 == `CTM_OP2_2 |=> cache_cmd.op == CTM_CLINV_D_IDX
		&& cache_cmd.segment == $past(wdata[`CTM_SET_HI:`CTM_SET_LO]))
		else $error("index clean and invalidate wrong");
	busy_set_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE1
		cop_next != CTM_CNONE |=> cache_busy)
		else $error("cache busy not raised");
	tlb_inv_i_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE15
		tlb_wr && coproc_operand_reg == `CTM_CRM_C5 && op2 == `CTM_OP2_0 |=> tlb_cmd.op == CTM_TINV_I_ALL)
		else $error("instruction TLB invalidate not issued");
	tlb_both_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE16
		tlb_wr && coproc_operand_reg == `CTM_CRM_C7 |=> tlb_cmd.op == CTM_TINV_ID_ALL)
		else $error("both TLB invalidate not issued");
	tlb_mva_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE17
		tlb_wr && coproc_operand_reg == `CTM_CRM_C6 && op2 == `CTM_OP2_1 |=> tlb_cmd.op == CTM_TINV_D_ENTRY
		&& tlb_cmd.mva == $past(wdata[`CTM_MVA_HI:`CTM_TLB_MVA_LO]))
		else $error("data TLB entry invalidate wrong");
	lock_wr_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE21
		clock_wr && op2 == `CTM_OP2_0 |=> dc_victim == dc_lock_base &&
		dc_lock_base == $past(wdata[`CTM_IDX_HI:`CTM_IDX_LO]))
		else $error("cache lockdown write wrong");
	lock_rd_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE20
		cp_rd && cp_xfer.reg_num == `CTM_REG_CACHE_LOCK && op2 == `CTM_OP2_1 |=>
		cp_rdata[`CTM_IDX_HI:`CTM_IDX_LO] == $past(ic_base_reg))
		else $error("cache lockdown read wrong");
	dc_wrap_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE19
		dc_linefill && !clock_wr && dc_victim == `CTM_TLB_TOP |=> dc_victim == dc_lock_base)
		else $error("cache victim did not wrap to base");
	tlock_wr_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE22
		tlock_wr && op2 == `CTM_OP2_1 |=> itlb_base == $past(wdata[`CTM_IDX_HI:`CTM_IDX_LO])
		&& itlb_victim == $past(wdata[`CTM_VIC_HI:`CTM_VIC_LO]))
		else $error("instruction TLB lockdown write wrong");
	tlb_range_a: assert property (@(posedge ref_clk) disable iff (!resetn) // RULE23
		dtlb_refill && !tlock_wr && dtlb_victim >= dtlb_base |=> dtlb_victim >= dtlb_base)
		else $error("TLB victim below base");
	tlbinv_c: cover property (@(posedge ref_clk) disable iff (!resetn)
		tlb_cmd.op == CTM_TINV_ID_ALL);
	wfi_c: cover property (@(posedge ref_clk) disable iff (!resetn) low_power ##1 !low_power);
	drain_c: cover property (@(posedge ref_clk) disable iff (!resetn)
		stall_reg == CTM_DRAIN ##1 !core_stall);
	clinv_c: cover property (@(posedge ref_clk) disable iff (!resetn)
		cache_cmd.op == CTM_CLINV_D_MVA);
	tlbwrap_c: cover property (@(posedge ref_clk) disable iff (!resetn)
		dtlb_refill && dtlb_victim == `CTM_TLB_TOP);
endmodule : ctm_maint

// ===== ctm_map.svh
// Register numbers, operation codes, field positions and reset values of the maintenance block
`ifndef CTM_MAP_SVH
`define CTM_MAP_SVH
`define CTM_REG_CACHE_OP 4'h7
`define CTM_REG_TLB_OP 4'h8
`define CTM_REG_CACHE_LOCK 4'h9
`define CTM_REG_TLB_LOCK 4'hA
`define CTM_CRM_C0 4'h0
`define CTM_CRM_C5 4'h5
`define CTM_CRM_C6 4'h6
`define CTM_CRM_C7 4'h7
`define CTM_CRM_C10 4'hA
`define CTM_CRM_C13 4'hD
`define CTM_CRM_C14 4'hE
`define CTM_OP2_0 3'h0
`define CTM_OP2_1 3'h1
`define CTM_OP2_2 3'h2
`define CTM_OP2_4 3'h4
`define CTM_MVA_HI 31
`define CTM_MVA_LO 5
`define CTM_TLB_MVA_LO 10
`define CTM_IDX_HI 31
`define CTM_IDX_LO 26
`define CTM_SET_HI 7
`define CTM_SET_LO 5
`define CTM_VIC_HI 25
`define CTM_VIC_LO 20
`define CTM_PRESERVE_BIT 0
`define CTM_LOCK_RESET 32'h0000_0000
`define CTM_PTR_RESET 6'h00
`define CTM_TLB_TOP 6'h3F
`define CTM_TLB_ENTRIES 64
`endif

// ===== ctm_pkg.sv
// Types shared by the cache and TLB maintenance block
package ctm_pkg;
	// One coprocessor register transfer from the core
	typedef struct packed {
		logic [3:0] reg_num;
		logic [3:0] operand_reg;
		logic [2:0] secondary_opcode;
		logic [31:0] data;
	} ctm_xfer_t;
	// Operation handed to the cache arrays
	typedef enum logic [3:0] {
		CTM_CNONE, CTM_INV_I_ALL, CTM_INV_I_LINE, CTM_INV_D_ALL, CTM_INV_D_LINE,
		CTM_INV_ID_ALL, CTM_CLEAN_D_MVA, CTM_CLEAN_D_IDX, CTM_PREFETCH_I,
		CTM_CLINV_D_MVA, CTM_CLINV_D_IDX
	} ctm_cache_op_t;
	// Operation handed to the TLBs
	typedef enum logic [2:0] {
		CTM_TNONE, CTM_TINV_I_ALL, CTM_TINV_I_ENTRY, CTM_TINV_D_ALL, CTM_TINV_D_ENTRY,
		CTM_TINV_ID_ALL
	} ctm_tlb_op_t;
	typedef struct packed {
		ctm_cache_op_t op;
		logic [26:0] mva;
		logic [5:0] line_index;
		logic [2:0] segment;
	} ctm_cache_cmd_t;
	typedef struct packed {
		ctm_tlb_op_t op;
		logic [21:0] mva;
	} ctm_tlb_cmd_t;
	// Run state and busy states of the core stall
	typedef enum logic [1:0] {CTM_RUN, CTM_WFI, CTM_DRAIN} ctm_stall_t;
endpackage : ctm_pkg

// ===== ctm_core_model.sv
// Processor core model issuing coprocessor register transfers
`timescale 1ns/100ps
module ctm_core_model
	import ctm_pkg::*;
(
	input wire logic ref_clk, // Core clock
	output logic cp_wr, // Write strobe
	output logic cp_rd, // Read strobe
	output ctm_xfer_t cp_xfer // Transfer fields
);
	// Quiet bus at start
	initial
	begin
		cp_wr = 1'b0;
		cp_rd = 1'b0;
		cp_xfer = '0;
	end
	// One transfer, launched and released at falling edges
	task xfer(input logic rd, input logic [3:0] rn, input logic [3:0] coproc_operand_reg,
		input logic [2:0] op2, input logic [31:0] d);
		@(negedge ref_clk);
		cp_xfer = {rn, coproc_operand_reg, op2, d};
		{cp_rd, cp_wr} = {rd, ~rd};
		@(negedge ref_clk);
		{cp_rd, cp_wr} = 2'b00;
		// Inverted fields so a stale value never looks valid
		cp_xfer = ~cp_xfer;
	endtask : xfer
endmodule : ctm_core_model

// ===== tb_cache_tlb_maintenance.sv
// Self-checking testbench of the cache and TLB maintenance block
`timescale 1ns/100ps
`include "ctm_map.svh"
module tb_cache_tlb_maintenance
	import ctm_pkg::*;
;
	localparam logic [31:0] MVA_D = 32'h8765_4320; // Bits 4:0 zero
	localparam logic [31:0] IDX_D = 32'hA400_00E0; // Line and segment only
	localparam logic [31:0] TLB_D = 32'h1234_5C00; // Bits 9:0 zero
	logic ref_clk, resetn, cp_wr, cp_rd, irq_pending, wbuf_empty, cache_done;
	logic dc_linefill, ic_linefill, dtlb_refill, itlb_refill;
	logic core_stall, low_power, cache_busy, dtlb_preserve, itlb_preserve;
	logic [31:0] cp_rdata;
	logic [5:0] dc_victim, ic_victim, dc_lock_base, ic_lock_base;
	logic [5:0] dtlb_victim, itlb_victim, dtlb_base, itlb_base;
	ctm_xfer_t cp_xfer;
	ctm_cache_cmd_t cache_cmd;
	ctm_tlb_cmd_t tlb_cmd;
	int n_errors, tests_run;

	ctm_core_model core (.ref_clk, .cp_wr, .cp_rd, .cp_xfer);
	ctm_maint DUT (.ref_clk, .resetn, .cp_wr, .cp_rd, .cp_xfer, .cp_rdata, .core_stall,
		.low_power, .irq_pending, .wbuf_empty, .cache_cmd, .cache_done, .tlb_cmd,
		.dc_victim, .ic_victim, .dc_lock_base, .ic_lock_base, .dc_linefill, .ic_linefill,
		.dtlb_victim, .itlb_victim, .dtlb_base, .itlb_base, .dtlb_preserve, .itlb_preserve,
		.dtlb_refill, .itlb_refill, .cache_busy);

	// Clock, 10 ns period
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task chk(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task wrap_up;
		$display("checks run %0d, mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : wrap_up

	task wr(input logic [3:0] rn, input logic [3:0] coproc_operand_reg, input logic [2:0] op2,
		input logic [31:0] d);
		core.xfer(1'b0, rn, coproc_operand_reg, op2, d);
	endtask : wr

	// Reads go only to the lockdown registers
	task rd(input logic [3:0] rn, input logic [2:0] op2, input logic [31:0] exp);
		core.xfer(1'b1, rn, `CTM_CRM_C0, op2, 32'h0);
		chk(cp_rdata, exp);
	endtask : rd

	task t_reset;
		chk({core_stall, low_power, cache_busy, dc_victim, ic_victim}, '0);
		chk({dtlb_victim, itlb_victim, dtlb_base, itlb_base}, '0);
		rd(`CTM_REG_CACHE_LOCK, `CTM_OP2_0, `CTM_LOCK_RESET);
		rd(`CTM_REG_CACHE_LOCK, `CTM_OP2_1, `CTM_LOCK_RESET);
		rd(`CTM_REG_TLB_LOCK, `CTM_OP2_0, `CTM_LOCK_RESET);
		rd(`CTM_REG_TLB_LOCK, `CTM_OP2_1, `CTM_LOCK_RESET);
	endtask : t_reset

	// One cache operation, then its completion
	task cache_one(input logic [3:0] coproc_operand_reg, input logic [2:0] op2, input logic [31:0] d,
		input ctm_cache_op_t exp);
		wr(`CTM_REG_CACHE_OP, coproc_operand_reg, op2, d);
		if (exp == CTM_CNONE)
			chk(cache_cmd.op, exp);
		else
			chk({cache_cmd, cache_busy}, {exp, d[31:5], d[31:26], d[7:5], 1'b1});
		cache_done = 1'b1;
		@(negedge ref_clk);
		cache_done = 1'b0;
		chk({cache_cmd.op, cache_busy}, {CTM_CNONE, 1'b0});
	endtask : cache_one

	task tlb_one(input logic [3:0] coproc_operand_reg, input logic [2:0] op2, input logic [31:0] d,
		input ctm_tlb_op_t exp);
		wr(`CTM_REG_TLB_OP, coproc_operand_reg, op2, d);
		chk(tlb_cmd, {exp, d[31:10]});
		@(negedge ref_clk);
		chk(tlb_cmd.op, CTM_TNONE);
	endtask : tlb_one

	// Stall held until its release input is seen
	task t_stall(input logic [3:0] coproc_operand_reg, input logic wfi);
		wbuf_empty = 1'b0;
		wr(`CTM_REG_CACHE_OP, coproc_operand_reg, `CTM_OP2_4, 32'h0);
		chk({core_stall, low_power}, {1'b1, wfi});
		repeat (3) @(negedge ref_clk);
		chk({core_stall, low_power}, {1'b1, wfi});
		{irq_pending, wbuf_empty} = {wfi, ~wfi};
		@(negedge ref_clk);
		chk({core_stall, low_power}, 2'b00);
		irq_pending = 1'b0;
		wbuf_empty = 1'b1;
	endtask : t_stall

	task t_clock(input logic [2:0] op2, input logic [5:0] b);
		logic [5:0] v;
		v = b;
		wr(`CTM_REG_CACHE_LOCK, `CTM_CRM_C0, op2, {b, 26'h0});
		repeat (3)
		begin
			chk(op2[0] ? {ic_lock_base, ic_victim} : {dc_lock_base, dc_victim}, {b, v});
			{ic_linefill, dc_linefill} = {op2[0], ~op2[0]};
			@(negedge ref_clk);
			{ic_linefill, dc_linefill} = 2'b00;
			v = (v == `CTM_TLB_TOP) ? b : v + 6'h01;
		end
		rd(`CTM_REG_CACHE_LOCK, op2, {b, 26'h0});
	endtask : t_clock

	task t_tlock(input logic [2:0] op2, input logic [5:0] b, input logic [5:0] vi,
		input logic p);
		logic [5:0] v;
		logic [31:0] d;
		d = {b, vi, 19'h0, p};
		v = vi;
		wr(`CTM_REG_TLB_LOCK, `CTM_CRM_C0, op2, d);
		repeat (3)
		begin
			chk(op2[0] ? {itlb_base, itlb_victim, itlb_preserve}
				: {dtlb_base, dtlb_victim, dtlb_preserve}, {b, v, p});
			{itlb_refill, dtlb_refill} = {op2[0], ~op2[0]};
			@(negedge ref_clk);
			{itlb_refill, dtlb_refill} = 2'b00;
			v = (v == `CTM_TLB_TOP || v < b) ? b : v + 6'h01;
		end
		// Victim field has moved on with the refills
		rd(`CTM_REG_TLB_LOCK, op2, {b, v, 19'h0, p});
	endtask : t_tlock

	// Reset again in mid-run; pointers and lockdown state must clear
	task t_midreset;
		resetn = 1'b0;
		repeat (2) @(negedge ref_clk);
		resetn = 1'b1;
		t_reset;
	endtask : t_midreset

	// Watchdog, far beyond the hundred or so cycles the run needs
	initial
	begin
		#50000;
		n_errors++;
		wrap_up;
	end

	initial
	begin
		{resetn, irq_pending, cache_done, dc_linefill, ic_linefill} = '0;
		{dtlb_refill, itlb_refill} = 2'b00;
		wbuf_empty = 1'b1;
		n_errors = 0;
		tests_run = 0;
		repeat (5) @(negedge ref_clk);
		resetn = 1'b1;
		t_reset;
		cache_one(`CTM_CRM_C5, `CTM_OP2_0, 32'h0, CTM_INV_I_ALL);
		cache_one(`CTM_CRM_C5, `CTM_OP2_1, MVA_D, CTM_INV_I_LINE);
		cache_one(`CTM_CRM_C6, `CTM_OP2_0, 32'h0, CTM_INV_D_ALL);
		cache_one(`CTM_CRM_C6, `CTM_OP2_1, MVA_D, CTM_INV_D_LINE);
		cache_one(`CTM_CRM_C7, `CTM_OP2_0, 32'h0, CTM_INV_ID_ALL);
		cache_one(`CTM_CRM_C10, `CTM_OP2_1, MVA_D, CTM_CLEAN_D_MVA);
		cache_one(`CTM_CRM_C10, `CTM_OP2_2, IDX_D, CTM_CLEAN_D_IDX);
		cache_one(`CTM_CRM_C13, `CTM_OP2_1, MVA_D, CTM_PREFETCH_I);
		cache_one(`CTM_CRM_C14, `CTM_OP2_1, MVA_D, CTM_CLINV_D_MVA);
		cache_one(`CTM_CRM_C14, `CTM_OP2_2, IDX_D, CTM_CLINV_D_IDX);
		cache_one(`CTM_CRM_C5, `CTM_OP2_2, MVA_D, CTM_CNONE);
		tlb_one(`CTM_CRM_C5, `CTM_OP2_0, 32'h0, CTM_TINV_I_ALL);
		tlb_one(`CTM_CRM_C5, `CTM_OP2_1, TLB_D, CTM_TINV_I_ENTRY);
		tlb_one(`CTM_CRM_C6, `CTM_OP2_0, 32'h0, CTM_TINV_D_ALL);
		tlb_one(`CTM_CRM_C6, `CTM_OP2_1, TLB_D, CTM_TINV_D_ENTRY);
		tlb_one(`CTM_CRM_C7, `CTM_OP2_0, 32'h0, CTM_TINV_ID_ALL);
		t_stall(`CTM_CRM_C0, 1'b1);
		t_stall(`CTM_CRM_C10, 1'b0);
		t_clock(`CTM_OP2_0, 6'h3E);
		t_clock(`CTM_OP2_1, 6'h05);
		t_tlock(`CTM_OP2_0, 6'h3C, 6'h3E, 1'b1);
		t_tlock(`CTM_OP2_1, 6'h0A, 6'h05, 1'b0);
		t_midreset;
		wrap_up;
	end
endmodule : tb_cache_tlb_maintenance
